/* rtl/dtf_consts.svh */
`ifndef DTF_CONSTS_SVH
`define DTF_CONSTS_SVH

// ****************************************
// Trace register offsets on the CPU bus
// ****************************************
`define DTF_OFS_TRACE_HIGH   2'h0
`define DTF_OFS_TRACE_LOW    2'h1
`define DTF_OFS_TRACE_CTRL   2'h2
`define DTF_OFS_TRACE_STAT   2'h3

// ****************************************
// Trace control and status fields
// ****************************************
`define DTF_TC_ENABLE        7
`define DTF_TC_ARM           6
`define DTF_TC_TAG           5
`define DTF_TC_BRK           4
`define DTF_TC_RESET         8'h00
`define DTF_TS_RUN           7
`define DTF_TRACE_DEPTH      8
`define DTF_TRACE_WIDTH      16

// ****************************************
// Debug status and control fields
// ****************************************
`define DTF_SC_BGEN          7
`define DTF_SC_ACTIVE        6
`define DTF_SC_BKPT_EN       5
`define DTF_SC_FORCE         4
`define DTF_SC_CLKSEL        3
`define DTF_SC_WAIT          2
`define DTF_SC_WAIT_SEEN     1
`define DTF_SC_VALID         0
`define DTF_SC_WMASK         8'hB8
`define DTF_SC_RESET         8'h00
`define DTF_BKPT_RESET       16'h0000

`endif

/* rtl/dtf_pkg.sv */
package dtf_pkg;

	// Trace run states, Gray along idle, armed, filling
	typedef enum logic [1:0] {
		DTF_ST_IDLE    = 2'h0,
		DTF_ST_ARMED   = 2'h1,
		DTF_ST_FILLING = 2'h3
	} dtf_run_t;

	// Decoded serial debug commands
	typedef enum logic [1:0] {
		DTF_CMD_READ_CTRL  = 2'h0,
		DTF_CMD_WRITE_CTRL = 2'h1,
		DTF_CMD_READ_BKPT  = 2'h2,
		DTF_CMD_WRITE_BKPT = 2'h3
	} dtf_cmd_t;

endpackage

/* rtl/dtf_bdc_regs.sv */
`timescale 1ns/100ps
`include "dtf_consts.svh"

module dtf_bdc_regs (
	input  wire logic             clock_i,       // Bus clock
	input  wire logic             rst_i,         // Sync reset
	input  wire logic             cmd_valid_i,   // Command strobe
	input  wire dtf_pkg::dtf_cmd_t cmd_op_i,     // Command code
	input  wire logic [15:0]      cmd_data_i,    // Write data
	input  wire logic             bg_active_i,   // CPU in background mode
	input  wire logic             wait_i,        // CPU in wait
	input  wire logic             wait_seen_i,   // Wait seen
	input  wire logic             data_valid_i,  // Serial data valid
	output logic [15:0]           cmd_rdata_o,   // Read data
	output logic                  cmd_done_o,    // Command done pulse
	output logic                  bg_enable_o,   // Background mode enable
	output logic                  bkpt_enable_o, // Breakpoint enable
	output logic                  force_sel_o,   // Breakpoint force type
	output logic                  clock_sel_o,   // Debug clock select
	output logic [15:0]           bkpt_addr_o    // Breakpoint address
);

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] bkpt;
		logic [15:0] rdata;
		logic        done;
	} dtf_bdc_state_t;

	dtf_bdc_state_t s;
	dtf_bdc_state_t next_s;
	logic [7:0]     status_byte;

	// Read-only flags come live from the core, never from storage
	always_comb begin
		status_byte = s.ctrl & `DTF_SC_WMASK;
		status_byte[`DTF_SC_ACTIVE]    = bg_active_i;
		status_byte[`DTF_SC_WAIT]      = wait_i;
		status_byte[`DTF_SC_WAIT_SEEN] = wait_seen_i;
		status_byte[`DTF_SC_VALID]     = data_valid_i;
	end

	// Command decode; only serial commands reach these registers
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (cmd_valid_i) begin
			next_s.done = 1'b1;
			case (cmd_op_i)
				dtf_pkg::DTF_CMD_READ_CTRL: next_s.rdata = {8'h00, status_byte};
				dtf_pkg::DTF_CMD_WRITE_CTRL: begin
					next_s.ctrl = cmd_data_i[7:0] & `DTF_SC_WMASK;
					if (bg_active_i) begin
						next_s.ctrl[`DTF_SC_BGEN] = s.ctrl[`DTF_SC_BGEN];
					end
				end
				dtf_pkg::DTF_CMD_READ_BKPT: next_s.rdata = s.bkpt;
				dtf_pkg::DTF_CMD_WRITE_BKPT: next_s.bkpt = cmd_data_i;
				default: next_s.done = 1'b1;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s <= '{ctrl: `DTF_SC_RESET, bkpt: `DTF_BKPT_RESET, rdata: 16'h0000, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign cmd_rdata_o   = s.rdata;
	assign cmd_done_o    = s.done;
	assign bg_enable_o   = s.ctrl[`DTF_SC_BGEN];
	assign bkpt_enable_o = s.ctrl[`DTF_SC_BKPT_EN];
	assign force_sel_o   = s.ctrl[`DTF_SC_FORCE];
	assign clock_sel_o   = s.ctrl[`DTF_SC_CLKSEL];
	assign bkpt_addr_o   = s.bkpt;

	property p_bgen_locked;
		@(posedge clock_i) disable iff (rst_i)
		cmd_valid_i && cmd_op_i == dtf_pkg::DTF_CMD_WRITE_CTRL && bg_active_i |=> $stable(bg_enable_o);
	endproperty
	a_bgen_locked: assert property (p_bgen_locked) else $error("enable changed in background mode");

	property p_clksel_any;
		@(posedge clock_i) disable iff (rst_i)
		cmd_valid_i && cmd_op_i == dtf_pkg::DTF_CMD_WRITE_CTRL |=> clock_sel_o == $past(cmd_data_i[3]);
	endproperty
	a_clksel_any: assert property (p_clksel_any) else $error("clock select not written");

endmodule

/* rtl/dtf_trace_buf.sv */
`timescale 1ns/100ps
`include "dtf_consts.svh"

module dtf_trace_buf #(
	parameter int DEPTH = `DTF_TRACE_DEPTH,
	parameter int WIDTH = `DTF_TRACE_WIDTH
) (
	input  wire logic             clock_i,  // Bus clock
	input  wire logic             rst_i,    // Sync reset
	input  wire logic             shift_i,  // Advance and insert
	input  wire logic [WIDTH-1:0] din_i,    // Word into last location
	output logic      [WIDTH-1:0] head_o    // Oldest word
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
	} dtf_buf_state_t;

	dtf_buf_state_t s;
	dtf_buf_state_t next_s;

	// Shift line: oldest at 0, new word lands in the last location
	always_comb begin
		next_s = s;
		if (shift_i) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_s.entry[i] = s.entry[i + 1];
			end
			next_s.entry[DEPTH-1] = din_i;
		end
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign head_o = s.entry[0];

	property p_insert_last;
		@(posedge clock_i) disable iff (rst_i)
		shift_i |=> s.entry[DEPTH-1] == $past(din_i) && s.entry[DEPTH-2] == $past(s.entry[DEPTH-1]);
	endproperty
	a_insert_last: assert property (p_insert_last) else $error("shift line broken");

endmodule

/* rtl/dtf_top.sv */
`timescale 1ns/100ps
`include "dtf_consts.svh"

module dtf_top #(
	parameter int DEPTH = `DTF_TRACE_DEPTH,
	parameter int WIDTH = `DTF_TRACE_WIDTH
) (
	input  wire logic              clock_i,         // Bus clock, 25 MHz
	input  wire logic              rst_i,           // Sync system reset
	input  wire logic              bus_sel_i,       // Trace register select
	input  wire logic              bus_rd_i,        // Read strobe
	input  wire logic              bus_wr_i,        // Write strobe
	input  wire logic [1:0]        bus_addr_i,      // Register offset
	input  wire logic [7:0]        bus_wdata_i,     // Write data
	output logic      [7:0]        bus_rdata_o,     // Read data, next cycle
	input  wire logic              cmd_valid_i,     // Serial command strobe
	input  wire dtf_pkg::dtf_cmd_t cmd_op_i,        // Serial command code
	input  wire logic [15:0]       cmd_data_i,      // Serial write data
	output logic      [15:0]       cmd_rdata_o,     // Serial read data
	output logic                   cmd_done_o,      // Command done pulse
	input  wire logic              bg_active_i,     // CPU in background mode
	input  wire logic              wait_i,          // CPU in wait
	input  wire logic              wait_seen_i,     // Wait seen
	input  wire logic              data_valid_i,    // Serial data valid
	output logic                   clock_sel_o,     // Debug clock select
	input  wire logic              secure_i,        // Device secured
	input  wire logic              fetch_i,         // Opcode fetch strobe
	input  wire logic [15:0]       fetch_addr_i,    // Opcode address
	input  wire logic              capture_valid_i, // Capture word strobe
	input  wire logic [WIDTH-1:0]  capture_data_i,  // Capture word
	input  wire logic              trigger_i,       // Trigger met
	input  wire logic              begin_trace_i,   // Begin-trace mode
	input  wire logic              event_only_i,    // Event-only mode
	output logic                   armed_o,         // Trace armed
	output logic                   break_req_o,     // Break request pulse
	output logic                   break_tag_o,     // 1 tag, 0 force
	output logic                   break_swi_o      // Take software interrupt
);

	// ****************************************
	// Local types and state
	// ****************************************
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		dtf_pkg::dtf_run_t run;
		logic [7:0]        ctrl;
		logic [CW-1:0]     count;
		logic [15:0]       last_op;
		logic [7:0]        rdata;
		logic              brk_req;
		logic              brk_tag;
		logic              brk_swi;
	} dtf_top_state_t;

	dtf_top_state_t   s;
	dtf_top_state_t   next_s;
	logic             wr_ctrl;
	logic             rd_high;
	logic             rd_low;
	logic             rd_any;
	logic             store;
	logic             buf_shift;
	logic [WIDTH-1:0] buf_din;
	logic [WIDTH-1:0] buf_head;
	logic             bg_enable;
	logic             bkpt_enable;
	logic             force_sel;
	logic [15:0]      bkpt_addr;
	logic             bkpt_hit;
	logic             run_done;
	logic             new_enable;

	// Event-only words keep just the low byte
	function automatic logic [WIDTH-1:0] shape_word(input logic evt, input logic [WIDTH-1:0] d);
		shape_word = evt ? {{(WIDTH-8){1'b0}}, d[7:0]} : d;
	endfunction

	// ****************************************
	// Debug controller registers
	// ****************************************
	dtf_bdc_regs u_bdc (
		.clock_i       (clock_i),
		.rst_i         (rst_i),
		.cmd_valid_i   (cmd_valid_i),
		.cmd_op_i      (cmd_op_i),
		.cmd_data_i    (cmd_data_i),
		.bg_active_i   (bg_active_i),
		.wait_i        (wait_i),
		.wait_seen_i   (wait_seen_i),
		.data_valid_i  (data_valid_i),
		.cmd_rdata_o   (cmd_rdata_o),
		.cmd_done_o    (cmd_done_o),
		.bg_enable_o   (bg_enable),
		.bkpt_enable_o (bkpt_enable),
		.force_sel_o   (force_sel),
		.clock_sel_o   (clock_sel_o),
		.bkpt_addr_o   (bkpt_addr)
	);

	// ****************************************
	// Trace buffer
	// ****************************************
	dtf_trace_buf #(
		.DEPTH (DEPTH),
		.WIDTH (WIDTH)
	) u_buf (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.shift_i (buf_shift),
		.din_i   (buf_din),
		.head_o  (buf_head)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	// Strobes from the CPU bus; high and low slots ignore writes
	always_comb begin
		wr_ctrl = bus_sel_i && bus_wr_i && bus_addr_i == `DTF_OFS_TRACE_CTRL;
		rd_high = bus_sel_i && bus_rd_i && bus_addr_i == `DTF_OFS_TRACE_HIGH;
		rd_low  = bus_sel_i && bus_rd_i && bus_addr_i == `DTF_OFS_TRACE_LOW;
		rd_any  = bus_sel_i && bus_rd_i;
	end

	// Breakpoint match against opcode fetches
	always_comb begin
		bkpt_hit = bkpt_enable && fetch_i && fetch_addr_i == bkpt_addr;
	end

	// Capture only while armed; begin trace waits for its trigger
	always_comb begin
		store = capture_valid_i && s.ctrl[`DTF_TC_ENABLE] &&
			((s.run == dtf_pkg::DTF_ST_ARMED && !begin_trace_i) || s.run == dtf_pkg::DTF_ST_FILLING);
	end

	// Buffer feed: captures while armed, profiling reads while idle
	always_comb begin
		buf_shift = 1'b0;
		buf_din   = shape_word(event_only_i, capture_data_i);
		if (store) begin
			buf_shift = 1'b1;
		end else if (rd_low && s.run == dtf_pkg::DTF_ST_IDLE) begin
			buf_shift = 1'b1;
			buf_din   = s.last_op;
		end
	end

	// Run completion per trace mode; qualifier plays no part in timing
	always_comb begin
		run_done = 1'b0;
		case (s.run)
			dtf_pkg::DTF_ST_ARMED: run_done = trigger_i && !begin_trace_i;
			dtf_pkg::DTF_ST_FILLING: run_done = store && s.count == CW'(DEPTH - 1);
			default: run_done = 1'b0;
		endcase
	end

	// Enable refuses a 0-to-1 step while secured
	always_comb begin
		new_enable = bus_wdata_i[`DTF_TC_ENABLE] && (!secure_i || s.ctrl[`DTF_TC_ENABLE]);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.brk_req = 1'b0;
		if (fetch_i) begin
			next_s.last_op = fetch_addr_i;
		end
		// Run sequencing
		case (s.run)
			dtf_pkg::DTF_ST_IDLE: next_s.count = s.count;
			dtf_pkg::DTF_ST_ARMED: begin
				if (store) begin
					next_s.count = (s.count == CW'(DEPTH)) ? s.count : s.count + CW'(1);
				end
				if (trigger_i && begin_trace_i) begin
					next_s.run   = dtf_pkg::DTF_ST_FILLING;
					next_s.count = '0;
				end
			end
			dtf_pkg::DTF_ST_FILLING: begin
				if (store) begin
					next_s.count = s.count + CW'(1);
				end
			end
			default: next_s.run = dtf_pkg::DTF_ST_IDLE;
		endcase
		// Completion clears the arm bit and may raise a break
		if (run_done) begin
			next_s.run = dtf_pkg::DTF_ST_IDLE;
			next_s.ctrl[`DTF_TC_ARM] = 1'b0;
			if (s.ctrl[`DTF_TC_BRK]) begin
				next_s.brk_req = 1'b1;
				next_s.brk_tag = s.ctrl[`DTF_TC_TAG];
				next_s.brk_swi = !bg_enable;
			end
		end
		// Breakpoint from the debug controller
		if (bkpt_hit) begin
			next_s.brk_req = 1'b1;
			next_s.brk_tag = !force_sel;
			next_s.brk_swi = !bg_enable;
		end
		// Software write wins over the run; a stop must be certain
		if (wr_ctrl) begin
			next_s.ctrl = bus_wdata_i;
			next_s.ctrl[`DTF_TC_ENABLE] = new_enable;
			if (bus_wdata_i[`DTF_TC_ARM] && new_enable) begin
				next_s.run   = dtf_pkg::DTF_ST_ARMED;
				next_s.count = '0;
			end else begin
				next_s.run = dtf_pkg::DTF_ST_IDLE;
				next_s.ctrl[`DTF_TC_ARM] = 1'b0;
			end
		end
		// Registered read data, one cycle after the strobe
		if (rd_any) begin
			case (bus_addr_i)
				`DTF_OFS_TRACE_HIGH: next_s.rdata = event_only_i ? 8'h00 : buf_head[15:8];
				`DTF_OFS_TRACE_LOW: next_s.rdata = buf_head[7:0];
				`DTF_OFS_TRACE_CTRL: next_s.rdata = s.ctrl;
				`DTF_OFS_TRACE_STAT: next_s.rdata = {s.run != dtf_pkg::DTF_ST_IDLE, 3'h0, 4'(s.count)};
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s.run     <= dtf_pkg::DTF_ST_IDLE;
			s.ctrl    <= `DTF_TC_RESET;
			s.count   <= '0;
			s.last_op <= 16'h0000;
			s.rdata   <= 8'h00;
			s.brk_req <= 1'b0;
			s.brk_tag <= 1'b0;
			s.brk_swi <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state flops
	assign bus_rdata_o = s.rdata;
	assign armed_o     = s.ctrl[`DTF_TC_ARM];
	assign break_req_o = s.brk_req;
	assign break_tag_o = s.brk_tag;
	assign break_swi_o = s.brk_swi;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_fill_last;
		s.run == dtf_pkg::DTF_ST_FILLING && store && s.count == CW'(DEPTH - 1) && !wr_ctrl;
	endsequence

	property p_secure_hold;
		@(posedge clock_i) disable iff (rst_i)
		wr_ctrl && secure_i && !s.ctrl[`DTF_TC_ENABLE] |=> !s.ctrl[`DTF_TC_ENABLE];
	endproperty
	a_secure_hold: assert property (p_secure_hold) else $error("enable set while secured");

	property p_arm_set;
		@(posedge clock_i) disable iff (rst_i)
		wr_ctrl && bus_wdata_i[7:6] == 2'h3 && !secure_i |=> armed_o && s.run == dtf_pkg::DTF_ST_ARMED;
	endproperty
	a_arm_set: assert property (p_arm_set) else $error("arm write did not arm");

	property p_stop;
		@(posedge clock_i) disable iff (rst_i)
		wr_ctrl && (!bus_wdata_i[`DTF_TC_ARM] || !bus_wdata_i[`DTF_TC_ENABLE])
			|=> !armed_o && s.run == dtf_pkg::DTF_ST_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("run not stopped");

	property p_end_break;
		@(posedge clock_i) disable iff (rst_i)
		s.run == dtf_pkg::DTF_ST_ARMED && trigger_i && !begin_trace_i && !wr_ctrl && s.ctrl[`DTF_TC_BRK]
			|=> break_req_o && break_tag_o == $past(s.ctrl[`DTF_TC_TAG]) && !armed_o;
	endproperty
	a_end_break: assert property (p_end_break) else $error("end trace break missing");

	property p_full_break;
		@(posedge clock_i) disable iff (rst_i)
		s_fill_last ##0 s.ctrl[`DTF_TC_BRK] |=> break_req_o ##1 (!break_req_o || $past(bkpt_hit));
	endproperty
	a_full_break: assert property (p_full_break) else $error("begin trace break missing");

	property p_no_break;
		@(posedge clock_i) disable iff (rst_i)
		!s.ctrl[`DTF_TC_BRK] && !bkpt_hit |=> !break_req_o;
	endproperty
	a_no_break: assert property (p_no_break) else $error("break while disabled");

	property p_high_zero;
		@(posedge clock_i) disable iff (rst_i)
		rd_high && event_only_i |=> bus_rdata_o == 8'h00;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("high byte not zero");

	property p_high_still;
		@(posedge clock_i) disable iff (rst_i)
		rd_high && !store |=> $stable(buf_head);
	endproperty
	a_high_still: assert property (p_high_still) else $error("high read moved buffer");

	property p_armed_block;
		@(posedge clock_i) disable iff (rst_i)
		rd_low && s.run != dtf_pkg::DTF_ST_IDLE && !store |=> $stable(buf_head);
	endproperty
	a_armed_block: assert property (p_armed_block) else $error("armed read advanced");

	property p_swi_pick;
		@(posedge clock_i) disable iff (rst_i)
		bkpt_hit |=> break_req_o && break_swi_o == !$past(bg_enable);
	endproperty
	a_swi_pick: assert property (p_swi_pick) else $error("wrong break route");

endmodule

/* bench/dtf_core_model.sv */
`timescale 1ns/100ps
// ****************************************
// CPU core stand-in: fetches and breaks
// ****************************************
module dtf_core_model (
	input  wire logic        clock_i,      // Bus clock
	input  wire logic        rst_i,        // Sync reset
	input  wire logic        step_i,       // Fetch one opcode
	input  wire logic        break_req_i,  // Break request pulse
	input  wire logic        break_tag_i,  // Break type, 1 tag
	input  wire logic        break_swi_i,  // Take software interrupt
	output logic             fetch_o,      // Opcode fetch pulse
	output logic      [15:0] fetch_addr_o, // Opcode address
	output int               breaks_o,     // Breaks taken so far
	output logic      [1:0]  last_brk_o    // Tag and interrupt of last break
);
	// Odd stride so both address bytes change on every fetch
	always_ff @(posedge clock_i) begin
		fetch_o <= step_i & ~rst_i;
		if (rst_i) begin
			fetch_addr_o <= 16'h1000;
			breaks_o     <= 0;
			last_brk_o   <= 2'b00;
		end else begin
			if (step_i)
				fetch_addr_o <= fetch_addr_o + 16'h0123;
			if (break_req_i) begin
				breaks_o   <= breaks_o + 1;
				last_brk_o <= {break_tag_i, break_swi_i};
			end
		end
	end
endmodule

/* bench/debug_trace_fifo_control_tb.sv */
`timescale 1ns/100ps
// ****************************************
// Bench for the trace and debug block
// ****************************************
module debug_trace_fifo_control_tb;
	logic clock_i = 0, rst_i = 1, bus_sel_i = 0, bus_rd_i = 0, bus_wr_i = 0, cmd_valid_i = 0, fetch_step = 0;
	logic bg_active_i = 0, wait_i = 0, wait_seen_i = 0, data_valid_i = 0, secure_i = 0, capture_valid_i = 0;
	logic trigger_i = 0, begin_trace_i = 0, event_only_i = 0, cmd_done_o, clock_sel_o, fetch_i, armed_o;
	logic break_req_o, break_tag_o, break_swi_o;
	logic [1:0] bus_addr_i = 0, last_brk;
	logic [7:0] bus_wdata_i = 0, bus_rdata_o, rd, h;
	logic [15:0] cmd_data_i = 0, capture_data_i = 0, cmd_rdata_o, fetch_addr_i;
	logic [15:0] fq[$];
	dtf_pkg::dtf_cmd_t cmd_op_i = dtf_pkg::DTF_CMD_READ_CTRL;
	int bad_count = 0, comparisons = 0, cycles = 0, breaks, nb;

	dtf_top dtf_top_inst (.clock_i, .rst_i, .bus_sel_i, .bus_rd_i, .bus_wr_i, .bus_addr_i, .bus_wdata_i,
		.bus_rdata_o, .cmd_valid_i, .cmd_op_i, .cmd_data_i, .cmd_rdata_o, .cmd_done_o, .bg_active_i, .wait_i,
		.wait_seen_i, .data_valid_i, .clock_sel_o, .secure_i, .fetch_i, .fetch_addr_i, .capture_valid_i,
		.capture_data_i, .trigger_i, .begin_trace_i, .event_only_i, .armed_o, .break_req_o, .break_tag_o,
		.break_swi_o);
	dtf_core_model dtf_core_model_inst (.clock_i, .rst_i, .step_i(fetch_step), .break_req_i(break_req_o),
		.break_tag_i(break_tag_o), .break_swi_i(break_swi_o), .fetch_o(fetch_i), .fetch_addr_o(fetch_addr_i),
		.breaks_o(breaks), .last_brk_o(last_brk));

	// Free-running 25 MHz clock
	initial begin
		forever #20 clock_i = ~clock_i;
	end

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Guard against a hang well beyond the expected run length
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			wrap_up;
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One CPU bus access; read data lands on the same edge that takes the strobe
	task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_i);
		bus_sel_i <= 1;
		bus_wr_i <= wr;
		bus_rd_i <= !wr;
		bus_addr_i <= a;
		bus_wdata_i <= d;
		@(posedge clock_i);
		bus_sel_i <= 0;
		bus_wr_i <= 0;
		bus_rd_i <= 0;
		#1 rd = bus_rdata_o;
	endtask

	task automatic cmd(input dtf_pkg::dtf_cmd_t op, input logic [15:0] d);
		@(posedge clock_i);
		cmd_valid_i <= 1;
		cmd_op_i <= op;
		cmd_data_i <= d;
		@(posedge clock_i);
		cmd_valid_i <= 0;
		#1 chk(cmd_done_o, 1, "command done");
	endtask

	task automatic fetch_one;
		@(posedge clock_i);
		fetch_step <= 1;
		@(posedge clock_i);
		fetch_step <= 0;
		#1 fq.push_back(fetch_addr_i);
		@(posedge clock_i);
	endtask

	task automatic cap(input logic [15:0] d, input logic t);
		@(posedge clock_i);
		capture_valid_i <= !t;
		trigger_i <= t;
		capture_data_i <= d;
		@(posedge clock_i);
		capture_valid_i <= 0;
		trigger_i <= 0;
	endtask

	task automatic t_reset;
		bus(0, 2, 0);
		chk(rd, 0, "trace control reset");
		cmd(dtf_pkg::DTF_CMD_READ_CTRL, 0);
		chk(cmd_rdata_o, 0, "status reset");
	endtask

	// Unarmed low reads form an eight-stage delay line of fetch addresses
	task automatic t_profile;
		for (int k = 0; k < 16; k++) begin
			fetch_one;
			bus(0, 0, 0);
			h = rd;
			bus(0, 0, 0);
			chk(rd, h, "high reread");
			bus(0, 1, 0);
			chk({h, rd}, k < 8 ? 16'h0000 : fq[k - 8], "profile word");
		end
		bus(1, 0, 8'hFF);
		bus(1, 1, 8'hFF);
		bus(0, 0, 0);
		chk(rd, fq[8][15:8], "trace regs read-only");
		@(posedge clock_i) event_only_i <= 1;
		bus(0, 0, 0);
		chk(rd, 0, "event-only high");
		@(posedge clock_i) event_only_i <= 0;
	endtask

	task automatic t_serial;
		@(posedge clock_i);
		wait_i <= 1;
		wait_seen_i <= 1;
		data_valid_i <= 1;
		cmd(dtf_pkg::DTF_CMD_WRITE_CTRL, 16'h00FF);
		cmd(dtf_pkg::DTF_CMD_READ_CTRL, 0);
		chk(cmd_rdata_o, 16'h00BF, "status flags");
		chk(clock_sel_o, 1, "clock select set");
		@(posedge clock_i) bg_active_i <= 1;
		cmd(dtf_pkg::DTF_CMD_WRITE_CTRL, 16'h0000);
		cmd(dtf_pkg::DTF_CMD_READ_CTRL, 0);
		chk(cmd_rdata_o, 16'h00C7, "enable kept while active");
		chk(clock_sel_o, 0, "clock select cleared");
		cmd(dtf_pkg::DTF_CMD_WRITE_BKPT, 16'hA5C3);
		cmd(dtf_pkg::DTF_CMD_READ_BKPT, 0);
		chk(cmd_rdata_o, 16'hA5C3, "breakpoint");
		@(posedge clock_i);
		{bg_active_i, wait_i, wait_seen_i, data_valid_i} <= 4'h0;
	endtask

	// Begin trace: fill after trigger, tag break when full
	task automatic t_begin;
		@(posedge clock_i) begin_trace_i <= 1;
		bus(1, 2, 8'hF0);
		chk(armed_o, 1, "armed");
		bus(0, 3, 0);
		chk(rd, 8'h80, "run status");
		nb = breaks;
		cap(0, 1);
		for (int i = 0; i < 8; i++) begin
			chk(breaks, nb, "no early break");
			// Odd captures in event-only mode keep just their low byte
			event_only_i <= i[0];
			cap(16'hC000 + i, 0);
		end
		event_only_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		chk(breaks, nb + 1, "full break");
		chk(last_brk, 2'b10, "tag break");
		bus(0, 2, 0);
		chk(rd, 8'hB0, "arm cleared");
		for (int i = 0; i < 8; i++) begin
			bus(0, 0, 0);
			h = rd;
			bus(0, 1, 0);
			chk({h, rd}, (i[0] ? 16'h0000 : 16'hC000) + i, "captured word");
		end
	endtask

	// Stops, secured enable, and end trace without and with breaks
	task automatic t_stop;
		@(posedge clock_i) begin_trace_i <= 0;
		bus(1, 2, 8'hC0);
		cap(0, 1);
		repeat (2) @(posedge clock_i);
		chk(armed_o, 0, "trigger ends run");
		chk(breaks, nb + 1, "no break when disabled");
		for (int i = 0; i < 2; i++) begin
			bus(1, 2, 8'hC0);
			bus(1, 2, i ? 8'h40 : 8'h80);
			chk(armed_o, 0, "manual stop");
		end
		@(posedge clock_i) secure_i <= 1;
		bus(1, 2, 8'h80);
		bus(0, 2, 0);
		chk(rd, 0, "secured enable");
		@(posedge clock_i) secure_i <= 0;
		cmd(dtf_pkg::DTF_CMD_WRITE_CTRL, 16'h0000);
		bus(1, 2, 8'hD0);
		cap(16'h0055, 0);
		cap(0, 1);
		repeat (2) @(posedge clock_i);
		chk(breaks, nb + 2, "trigger break");
		chk(last_brk, 2'b01, "force break as interrupt");
	endtask

	// Breakpoint on the next opcode fetch, force type, background enabled
	task automatic t_bkpt;
		cmd(dtf_pkg::DTF_CMD_WRITE_CTRL, 16'h00B0);
		cmd(dtf_pkg::DTF_CMD_WRITE_BKPT, fq[$] + 16'h0123);
		fetch_one;
		repeat (2) @(posedge clock_i);
		chk(breaks, nb + 3, "breakpoint break");
		chk(last_brk, 2'b00, "force break to background");
	endtask

	// Reset held 20 cycles, then the scenarios in order
	initial begin
		repeat (20) @(posedge clock_i);
		rst_i <= 0;
		t_reset;
		t_profile;
		t_serial;
		t_begin;
		t_stop;
		t_bkpt;
		wrap_up;
	end
endmodule
